// ### verilog/uart_cfg_pkg.sv
package uart_cfg_pkg;
  // bus geometry
  localparam int AXI_AW = 5;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_FRAME  = 5'h00;
  localparam logic [AXI_AW-1:0] OFS_DIV_LO = 5'h04;
  localparam logic [AXI_AW-1:0] OFS_DIV_HI = 5'h08;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 5'h0C;
  localparam logic [AXI_AW-1:0] OFS_TXDATA = 5'h10;
  localparam logic [AXI_AW-1:0] OFS_RXDATA = 5'h14;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 5'h18;
  localparam logic [AXI_AW-1:0] OFS_MASK   = 5'h1C;

  // frame_format_control fields
  localparam int FRM_POL  = 0;
  localparam int FRM_CSZ  = 1;
  localparam int FRM_STOP = 3;
  localparam int FRM_PAR  = 4;
  localparam int FRM_MODE = 6;
  localparam logic [7:0] FRAME_RST = 8'h06;

  // control and receive data fields
  localparam int CTL_DSPEED = 0;
  localparam int CTL_CSZ_HI = 1;
  localparam int CTL_BUSY   = 7;
  localparam int RXD_PERR   = 9;

  // field encodings
  localparam logic [1:0] MODE_SYNC = 2'b01;
  localparam logic [1:0] PAR_OFF   = 2'b00;
  localparam logic [1:0] PAR_EVEN  = 2'b10;
  localparam logic [1:0] PAR_ODD   = 2'b11;
  localparam logic [2:0] CSZ_NINE  = 3'h7;

  // baud clock divide factors and divisor widths
  localparam logic [4:0] DIV_NORMAL = 5'h10;
  localparam logic [4:0] DIV_DOUBLE = 5'h08;
  localparam logic [4:0] DIV_SYNC   = 5'h02;
  localparam int DIV_W   = 12;
  localparam int DIV_LOW = 8;

  // interrupt status bits
  localparam int INT_W   = 3;
  localparam int INT_TX  = 0;
  localparam int INT_RX  = 1;
  localparam int INT_PAR = 2;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} frame_st_t;
endpackage

// ### verilog/baud_prescaler.sv
module baud_prescaler #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // divisor and reload
  input  wire logic [W-1:0] divisor,
  input  wire logic         reload,
  // baud clock enable, one tick every divisor+1 cycles
  output logic              tick
);
  logic [W-1:0] count_q;

  if (W < 1 || W > 16) begin : g_chk
    $error("baud_prescaler: W out of range");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (reload || count_q == '0) begin
      count_q <= divisor;
    end else begin
      count_q <= count_q - 1'b1;
    end
  end

  assign tick = (count_q == '0) && !reload;

  a_reload_value: assert property (@(posedge aclk) disable iff (!aresetn)
    reload |=> count_q == $past(divisor))
    else $error("prescaler did not reload from divisor");
  a_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
    (count_q != '0 && !reload) |=> count_q == $past(count_q) - 1'b1)
    else $error("prescaler did not count down");
endmodule

// ### verilog/uart_frame_core.sv
// What this block does
// - transmitter inserts computed parity bit when enabled
// - parity field: off, reserved, even, odd
// - receiver checks parity, flags mismatching character
// - stop select gives one or two stop bits
// - receiver ignores the stop select setting
// - size code gives 5,6,7,8 or 9 bits
// - sync polarity picks launch and sample edges
// - 12-bit divisor split over high/low bytes
// - low byte write reloads prescaler at once
// - double speed changes divide 16 to 8
//
// The AXI4-Lite register port and the register offsets were decided locally.
module uart_frame_core (
  // clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // axi4-lite write
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [uart_cfg_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                             wvalid,
  output logic                                  wready,
  input  wire logic [uart_cfg_pkg::AXI_DW-1:0]  wdata,
  input  wire logic [3:0]                       wstrb,
  output logic                                  bvalid,
  input  wire logic                             bready,
  output logic [1:0]                            bresp,
  // axi4-lite read
  input  wire logic                             arvalid,
  output logic                                  arready,
  input  wire logic [uart_cfg_pkg::AXI_AW-1:0]  araddr,
  output logic                                  rvalid,
  input  wire logic                             rready,
  output logic [uart_cfg_pkg::AXI_DW-1:0]       rdata,
  output logic [1:0]                            rresp,
  // serial pins
  output logic                                  transmit_line,
  input  wire logic                             receive_line,
  output logic                                  sync_serial_clock,
  // interrupt
  output logic                                  irq
);
  import uart_cfg_pkg::*;

  logic [7:0]        frame_q;
  logic [7:0]        div_lo_q;
  logic [3:0]        div_hi_q;
  logic [1:0]        ctl_q;
  logic [INT_W-1:0]  status_q;
  logic [INT_W-1:0]  mask_q;
  logic              irq_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic [AXI_AW-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wbit8_q;
  logic              wlane_q;
  logic              do_wr, wr_en, reload, tick;
  logic [DIV_W-1:0]  div_val;
  logic [31:0]       rd_val;
  logic              rd_err;

  // frame configuration decode
  logic [1:0] par_mode;
  logic       par_en, stop2, pol, sync_mode;
  logic [2:0] csz;
  logic [3:0] char_len;
  logic [4:0] factor;
  logic [3:0] half, last;
  logic [8:0] len_mask;

  assign par_mode  = frame_q[FRM_PAR +: 2];
  assign par_en    = (par_mode == PAR_EVEN) || (par_mode == PAR_ODD);
  assign stop2     = frame_q[FRM_STOP];
  assign pol       = frame_q[FRM_POL];
  assign sync_mode = frame_q[FRM_MODE +: 2] == MODE_SYNC;
  assign csz       = {ctl_q[CTL_CSZ_HI], frame_q[FRM_CSZ +: 2]};
  // reserved size codes fall back to eight bits
  assign char_len  = (csz == CSZ_NINE) ? 4'd9 : csz[2] ? 4'd8 : {2'b01, csz[1:0]} + 4'd1;
  assign len_mask  = 9'h1FF >> (4'd9 - char_len);
  assign factor    = sync_mode ? DIV_SYNC : ctl_q[CTL_DSPEED] ? DIV_DOUBLE : DIV_NORMAL;
  assign half      = factor[4:1] - 4'd1 + 4'd1;
  assign last      = 4'(factor - 5'd1);

  baud_prescaler #(.W(DIV_W)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor (div_val),
    .reload  (reload),
    .tick    (tick)
  );

  // axi write channel
  assign do_wr  = !awready_q && !wready_q && !bvalid_q;
  assign wr_en  = do_wr && wlane_q;
  assign reload = wr_en && waddr_q[AXI_AW-1:2] == OFS_DIV_LO[AXI_AW-1:2];
  // reload must see the new low byte, not the one being replaced
  assign div_val = reload ? {div_hi_q, wbyte_q} : {div_hi_q, div_lo_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      waddr_q   <= '0;
      wbyte_q   <= '0;
      wbit8_q   <= 1'b0;
      wlane_q   <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wbyte_q  <= wdata[7:0];
        wbit8_q  <= wdata[8];
        wlane_q  <= wstrb[0];
      end
      if (do_wr) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q  <= 1'b1;
        bresp_q   <= (waddr_q[AXI_AW-1:2] == OFS_RXDATA[AXI_AW-1:2]) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q  <= FRAME_RST;
      div_lo_q <= '0;
      div_hi_q <= '0;
      ctl_q    <= '0;
      mask_q   <= '0;
    end else if (wr_en) begin
      unique case (waddr_q[AXI_AW-1:2])
        OFS_FRAME[AXI_AW-1:2]:  frame_q  <= wbyte_q;
        OFS_DIV_LO[AXI_AW-1:2]: div_lo_q <= wbyte_q;
        OFS_DIV_HI[AXI_AW-1:2]: div_hi_q <= wbyte_q[3:0];
        OFS_CTRL[AXI_AW-1:2]:   ctl_q    <= {wbyte_q[CTL_CSZ_HI], wbyte_q[CTL_DSPEED]};
        OFS_MASK[AXI_AW-1:2]:   mask_q   <= wbyte_q[INT_W-1:0];
        default: ;
      endcase
    end
  end

  // transmitter
  frame_st_t  tx_st;
  logic [3:0] tx_ph, tx_cnt;
  logic [8:0] tx_sh;
  logic       tx_par_q, tx_line_q, sck_q, tx_stop_q, tx_done_q, tx_go, tx_end;

  assign tx_go  = wr_en && waddr_q[AXI_AW-1:2] == OFS_TXDATA[AXI_AW-1:2] && tx_st == ST_IDLE;
  assign tx_end = tick && tx_ph == last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st     <= ST_IDLE;
      tx_ph     <= '0;
      tx_cnt    <= '0;
      tx_sh     <= '0;
      tx_par_q  <= 1'b0;
      tx_line_q <= 1'b1;
      sck_q     <= 1'b0;
      tx_stop_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      if (tx_st == ST_IDLE) begin
        tx_ph <= '0;
        sck_q <= pol;
        if (tx_go) begin
          tx_st     <= ST_START;
          tx_sh     <= {ctl_q[CTL_CSZ_HI] & wbit8_q, wbyte_q} & len_mask;
          tx_par_q  <= ^({ctl_q[CTL_CSZ_HI] & wbit8_q, wbyte_q} & len_mask) ^ par_mode[0];
          tx_line_q <= 1'b0;
          sck_q     <= ~pol;
        end
      end else if (tick) begin
        tx_ph <= tx_end ? 4'd0 : tx_ph + 4'd1;
        if (tx_ph == half - 4'd1) begin
          sck_q <= pol;
        end
        if (tx_end) begin
          sck_q <= ~pol;
          unique case (tx_st)
            ST_START: begin
              tx_st     <= ST_DATA;
              tx_line_q <= tx_sh[0];
              tx_sh     <= tx_sh >> 1;
              tx_cnt    <= 4'd1;
            end
            ST_DATA: begin
              if (tx_cnt == char_len) begin
                tx_st     <= par_en ? ST_PAR : ST_STOP;
                tx_line_q <= par_en ? tx_par_q : 1'b1;
                tx_stop_q <= 1'b0;
              end else begin
                tx_line_q <= tx_sh[0];
                tx_sh     <= tx_sh >> 1;
                tx_cnt    <= tx_cnt + 4'd1;
              end
            end
            ST_PAR: begin
              tx_st     <= ST_STOP;
              tx_line_q <= 1'b1;
              tx_stop_q <= 1'b0;
            end
            ST_STOP: begin
              if (stop2 && !tx_stop_q) begin
                tx_stop_q <= 1'b1;
              end else begin
                tx_st     <= ST_IDLE;
                tx_done_q <= 1'b1;
                sck_q     <= pol;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // receiver: one stop bit sampled whatever stop2 says
  frame_st_t  rx_st;
  logic [3:0] rx_ph, rx_cnt;
  logic [8:0] rx_sh, rx_data_q;
  logic       rx_xor_q, rx_bad_q, rx_perr_q, rx_done_q, rx_pev_q, rx_smp;

  assign rx_smp = tick && rx_ph == half;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st     <= ST_IDLE;
      rx_ph     <= '0;
      rx_cnt    <= '0;
      rx_sh     <= '0;
      rx_xor_q  <= 1'b0;
      rx_bad_q  <= 1'b0;
      rx_data_q <= '0;
      rx_perr_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_pev_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rx_pev_q  <= 1'b0;
      if (rx_st == ST_IDLE) begin
        rx_ph <= '0;
        if (!receive_line) begin
          rx_st    <= ST_START;
          rx_cnt   <= '0;
          rx_xor_q <= 1'b0;
          rx_bad_q <= 1'b0;
        end
      end else if (tick) begin
        rx_ph <= (rx_ph == last) ? 4'd0 : rx_ph + 4'd1;
        if (rx_smp) begin
          unique case (rx_st)
            ST_START: rx_st <= receive_line ? ST_IDLE : ST_DATA;
            ST_DATA: begin
              rx_sh    <= {receive_line, rx_sh[8:1]};
              rx_xor_q <= rx_xor_q ^ receive_line;
              rx_cnt   <= rx_cnt + 4'd1;
              if (rx_cnt + 4'd1 == char_len) begin
                rx_st <= par_en ? ST_PAR : ST_STOP;
              end
            end
            ST_PAR: begin
              rx_bad_q <= rx_xor_q ^ receive_line ^ par_mode[0];
              rx_st    <= ST_STOP;
            end
            ST_STOP: begin
              rx_st     <= ST_IDLE;
              rx_data_q <= rx_sh >> (4'd9 - char_len);
              rx_perr_q <= par_en & rx_bad_q;
              rx_pev_q  <= par_en & rx_bad_q;
              rx_done_q <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // interrupt status, write one to clear, set wins
  logic [INT_W-1:0] ev, clr;
  assign ev  = {rx_pev_q, rx_done_q, tx_done_q};
  assign clr = (wr_en && waddr_q[AXI_AW-1:2] == OFS_STATUS[AXI_AW-1:2]) ? wbyte_q[INT_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      irq_q    <= |(status_q & mask_q);
    end
  end

  // axi read channel
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    unique case (araddr[AXI_AW-1:2])
      OFS_FRAME[AXI_AW-1:2]:  rd_val[7:0] = frame_q;
      OFS_DIV_LO[AXI_AW-1:2]: rd_val[7:0] = div_lo_q;
      OFS_DIV_HI[AXI_AW-1:2]: rd_val[3:0] = div_hi_q;
      OFS_CTRL[AXI_AW-1:2]:   begin
        rd_val[CTL_DSPEED] = ctl_q[0];
        rd_val[CTL_CSZ_HI] = ctl_q[1];
        rd_val[CTL_BUSY]   = tx_st != ST_IDLE;
      end
      OFS_TXDATA[AXI_AW-1:2]: rd_err = 1'b1;
      OFS_RXDATA[AXI_AW-1:2]: rd_val[RXD_PERR:0] = {rx_perr_q, rx_data_q};
      OFS_STATUS[AXI_AW-1:2]: rd_val[INT_W-1:0] = status_q;
      OFS_MASK[AXI_AW-1:2]:   rd_val[INT_W-1:0] = mask_q;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_val;
      rresp_q   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign awready           = awready_q;
  assign wready            = wready_q;
  assign bvalid            = bvalid_q;
  assign bresp             = bresp_q;
  assign arready           = arready_q;
  assign rvalid            = rvalid_q;
  assign rdata             = rdata_q;
  assign rresp             = rresp_q;
  assign transmit_line     = tx_line_q;
  assign sync_serial_clock = sck_q;
  assign irq               = irq_q;

  a_parity_bit_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_PAR) |-> transmit_line == tx_par_q)
    else $error("parity bit on line does not match");
  a_reserved_no_par: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_DATA && tx_end && tx_cnt == char_len && par_mode == 2'b01)
    |=> tx_st == ST_STOP)
    else $error("reserved parity mode sent a parity bit");
  a_rx_par_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_st == ST_STOP && rx_smp && par_en && rx_bad_q) |=> ##1 status_q[INT_PAR])
    else $error("parity mismatch not flagged");
  a_one_stop_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_STOP && tx_end && !stop2) |=> tx_st == ST_IDLE && tx_done_q)
    else $error("single stop bit not honoured");
  a_two_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_STOP && tx_end && stop2 && !tx_stop_q) |=> tx_st == ST_STOP && transmit_line)
    else $error("second stop bit missing");
  a_rx_stop_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_st == ST_STOP && rx_smp) |=> rx_st == ST_IDLE && rx_done_q)
    else $error("receiver did not finish after one stop bit");
  a_nine_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_DATA && tx_end && tx_cnt == 4'd9) |-> csz == CSZ_NINE)
    else $error("nine bit size code mis-decoded");
  a_sck_idle_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st == ST_IDLE && $past(tx_st) == ST_IDLE && !$past(tx_go)) |-> sync_serial_clock == $past(pol))
    else $error("idle serial clock level wrong");
  a_double_factor: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync_mode && ctl_q[CTL_DSPEED]) |-> factor == DIV_DOUBLE && last == 4'd7)
    else $error("double speed factor not eight");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == $past(|(status_q & mask_q)))
    else $error("interrupt level does not follow status and mask");
endmodule

// ### tb/serial_node.sv
module serial_node (
  // clock
  input  wire logic aclk,
  // serial lines from and to the device
  input  wire logic line_in,
  input  wire logic sclk_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial line_out = 1'b1;

  // async capture: start, n bits lsb first, stop checked high;
  // gap runs from mid-stop of the frame before, plus half a bit
  task automatic get_async(input int n, input int bt, output int val, output int gap);
    val = 0;
    gap = bt / 2;
    do begin
      @(negedge aclk);
      gap++;
    end while (line_in !== 1'b0);
    repeat (bt / 2) @(negedge aclk);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(negedge aclk);
      if (line_in === 1'b1) val = val | (1 << i);
    end
    repeat (bt) @(negedge aclk);
    if (line_in !== 1'b1) val = -1;
  endtask

  // sync capture on the sampling edge of the serial clock
  task automatic get_sync(input int n, input logic pol, output int val);
    logic prev;
    int   k;
    val = 0;
    k = -1;
    prev = sclk_in;
    while (k < n) begin
      @(negedge aclk);
      if (sclk_in !== prev && sclk_in === pol) begin
        if (k < 0 && line_in !== 1'b0) val = -1;
        if (k >= 0 && line_in === 1'b1) val = val | (1 << k);
        k++;
      end
      prev = sclk_in;
    end
  endtask

  // exact bit time, one stop bit
  task automatic send(input int bits, input int n, input int bt);
    for (int i = -1; i <= n; i++) begin
      line_out <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : bits[i];
      repeat (bt) @(posedge aclk);
    end
  endtask
endmodule

// ### tb/usart_frame_format_and_baud_tb_top.sv
module usart_frame_format_and_baud_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_cfg_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, arvalid;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              transmit_line, receive_line, sync_serial_clock, irq;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  int                mismatches = 0;
  int                checks_done = 0;
  int                seed = 44;
  int                cyc = 0;

  uart_frame_core dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
    .transmit_line(transmit_line), .receive_line(receive_line),
    .sync_serial_clock(sync_serial_clock), .irq(irq)
  );

  serial_node node (
    .aclk(aclk), .line_in(transmit_line), .sclk_in(sync_serial_clock),
    .line_out(receive_line)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rd_chk(input string name, input logic [AXI_AW-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(name, d, exp);
    check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    do axi_read(OFS_CTRL, d, r); while (d[CTL_BUSY] !== 1'b0);
  endtask

  function automatic int nbits(int c);
    return c < 4 ? 5 + c : (c == 7 ? 9 : 8);
  endfunction

  // data bits lsb first, then parity bit if enabled
  function automatic int frame_val(int d, int c, int p);
    int n, v;
    n = nbits(c);
    v = d & ((1 << n) - 1);
    if (p >= 2) v = v | ((^v ^ (p & 1)) << n);
    return v;
  endfunction

  initial begin
    int          par, stp, dbl, bt, n, d1, d2, v1, v2, g;
    logic [31:0] rd;
    logic [1:0]  rr;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("frame_rst", OFS_FRAME, {24'h0, FRAME_RST});
    rd_chk("ctrl_rst", OFS_CTRL, 32'h0);
    rd_chk("stat_rst", OFS_STATUS, 32'h0);
    rd_chk("mask_rst", OFS_MASK, 32'h0);
    axi_read(OFS_TXDATA, rd, rr);
    check("rd_txdata", {rd[29:0], rr}, {30'h0, RESP_SLVERR});
    axi_write(OFS_RXDATA, 32'h55, 4'h1, RESP_SLVERR);
    axi_write(OFS_FRAME, 32'h36, 4'h0, RESP_OKAY);
    rd_chk("frame_nostrb", OFS_FRAME, {24'h0, FRAME_RST});
    axi_write(OFS_DIV_HI, 32'h0A, 4'h1, RESP_OKAY);
    axi_write(OFS_DIV_LO, 32'h5C, 4'h1, RESP_OKAY);
    rd_chk("div_hi", OFS_DIV_HI, 32'h0A);
    rd_chk("div_lo", OFS_DIV_LO, 32'h5C);
    axi_write(OFS_DIV_HI, 32'h00, 4'h1, RESP_OKAY);
    axi_write(OFS_DIV_LO, 32'h01, 4'h1, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      par = (i + 1) % 4;
      stp = i % 2;
      dbl = (i >= 6) ? 1 : 0;
      bt = (dbl == 1 ? 8 : 16) * 2;
      n = nbits(i) + ((par >= 2) ? 1 : 0);
      axi_write(OFS_CTRL, ((i >> 2) << 1) | dbl, 4'h1, RESP_OKAY);
      axi_write(OFS_FRAME, (par << 4) | (stp << 3) | ((i & 3) << 1), 4'h1, RESP_OKAY);
      d1 = $random(seed) & 32'h1FF;
      d2 = $random(seed) & 32'h1FF;
      fork
        begin
          node.get_async(n, bt, v1, g);
          node.get_async(n, bt, v2, g);
        end
        begin
          axi_write(OFS_TXDATA, d1, 4'h1, RESP_OKAY);
          wait_idle();
          axi_write(OFS_TXDATA, d2, 4'h1, RESP_OKAY);
        end
      join
      check("frame_a", v1, frame_val(d1, i, par));
      check("frame_b", v2, frame_val(d2, i, par));
      check("stop_gap", {31'h0, g >= (stp + 1) * bt && g < (stp + 2) * bt}, 32'h1);
      wait_idle();
    end
    rd_chk("stat_tx", OFS_STATUS, 32'h1);
    check("irq_masked", {31'h0, irq}, 32'h0);
    axi_write(OFS_MASK, 32'h1, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq_on", {31'h0, irq}, 32'h1);
    axi_write(OFS_STATUS, 32'h1, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    axi_write(OFS_CTRL, 32'h0, 4'h1, RESP_OKAY);
    axi_write(OFS_FRAME, 32'h2E, 4'h1, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      d1 = $random(seed) & 32'hFF;
      if (k == 2) node.send(frame_val(d1 ^ 32'h5A, 3, 2), 9, 32);
      node.send(frame_val(d1, 3, 2) ^ ((k == 1) ? 32'h100 : 32'h0), 9, 32);
      do axi_read(OFS_STATUS, rd, rr); while (rd[INT_RX] !== 1'b1);
      check("irq_rx_masked", {31'h0, irq}, 32'h0);
      check("perr_stat", {31'h0, rd[INT_PAR]}, (k == 1) ? 32'h1 : 32'h0);
      rd_chk("rxdata", OFS_RXDATA, ((k == 1) ? 32'h200 : 32'h0) | d1);
      axi_write(OFS_STATUS, 32'h7, 4'h1, RESP_OKAY);
    end
    for (int p = 0; p < 2; p++) begin
      axi_write(OFS_FRAME, (MODE_SYNC << FRM_MODE) | 32'h06 | p, 4'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("sclk_idle", {31'h0, sync_serial_clock}, p);
      d1 = $random(seed) & 32'hFF;
      fork
        node.get_sync(8, p[0], v1);
        axi_write(OFS_TXDATA, d1, 4'h1, RESP_OKAY);
      join
      check("sync_frame", v1, d1);
      wait_idle();
    end
    end_sim();
  end
endmodule
